// ### rtl/sba_burst_counter.sv
// two-bit wraparound burst counter, linear or interleaved order
`timescale 1ns/1ps
`default_nettype none
module sba_burst_counter (
   input  wire logic     clock,
   input  wire logic     rst_n,
   input  wire logic     clk_en,
   sba_burst_if.counter  bus
);
   logic [1:0] start;
   logic [1:0] beat;
   logic [1:0] next_start;
   logic [1:0] next_beat;
   logic [1:0] beat_inc;

   always_comb begin
      beat_inc = beat + sba_pkg::BEAT_STEP;
      // low bits follow from start and beat index
      if (bus.order == sba_pkg::ORDER_INTERLEAVED) begin
         bus.low_addr = start ^ beat;
         bus.low_next = start ^ beat_inc;
      end else begin
         bus.low_addr = start + beat;
         bus.low_next = start + beat_inc;
      end
      next_start = start;
      next_beat  = beat;
      if (bus.load) begin
         next_start = bus.load_value;
         next_beat  = sba_pkg::RESET_LOW;
      end else if (bus.step) begin
         next_beat  = beat_inc;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         start <= sba_pkg::RESET_LOW;
         beat  <= sba_pkg::RESET_LOW;
      end else if (clk_en) begin
         start <= next_start;
         beat  <= next_beat;
      end
   end

   property p_linear_step;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && bus.step && !bus.load && bus.order == sba_pkg::ORDER_LINEAR)
         |=> (bus.low_addr == $past(bus.low_addr) + 2'h1);
   endproperty
   a_linear_step: assert property (p_linear_step) else $error("linear step wrong");

   property p_interleave_second;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && bus.load && bus.order == sba_pkg::ORDER_INTERLEAVED)
         ##1 (clk_en && bus.step && !bus.load)
         |=> (bus.low_addr == ($past(bus.load_value, 2) ^ 2'h1));
   endproperty
   a_interleave_second: assert property (p_interleave_second) else $error("interleave wrong");

   property p_hold;
      @(posedge clock) disable iff (!rst_n)
      (clk_en && !bus.step && !bus.load) |=> $stable(bus.low_addr);
   endproperty
   a_hold: assert property (p_hold) else $error("suspended burst moved");
endmodule : sba_burst_counter
`default_nettype wire

// ### rtl/sba_burst_if.sv
// bundle between the access control and the burst address counter
`timescale 1ns/1ps
`default_nettype none
interface sba_burst_if;
   logic       load;
   logic [1:0] load_value;
   logic       step;
   logic       order;
   logic [1:0] low_addr;
   logic [1:0] low_next;

   modport ctrl (
      output load,
      output load_value,
      output step,
      output order,
      input  low_addr,
      input  low_next
   );
   modport counter (
      input  load,
      input  load_value,
      input  step,
      input  order,
      output low_addr,
      output low_next
   );
endinterface : sba_burst_if
`default_nettype wire

// ### rtl/sba_pkg.sv
// shared constants and types of the synchronous burst sram access block
package sba_pkg;
   localparam int ADDR_WIDTH             = 18;
   localparam int LANES                  = 4;
   localparam int LANE_BITS              = 8;
   localparam int LOW_BITS               = 2;
   localparam int CLOCK_PERIOD_NS        = 100;
   // sleep entry, sleep exit and sleep_recovery_time, in clock periods
   localparam int SLEEP_TRANSITION_TCYC  = 2;
   localparam int SLEEP_TRANSITION_CYCLES =
      (SLEEP_TRANSITION_TCYC * CLOCK_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam logic ORDER_LINEAR         = 1'h0;
   localparam logic ORDER_INTERLEAVED    = 1'h1;
   localparam logic RESET_ORDER          = ORDER_INTERLEAVED;
   localparam logic [1:0] RESET_LOW      = 2'h0;
   localparam logic [1:0] BEAT_STEP      = 2'h1;
   localparam logic RESET_OE_SYNC_N      = 1'h1;
   localparam logic RESET_SLEEP_SYNC     = 1'h0;

   typedef enum logic {
      SBA_DESEL = 1'b0,
      SBA_SEL   = 1'b1
   } sba_sel_type;

   typedef enum logic [1:0] {
      SBA_AWAKE    = 2'b00,
      SBA_ENTERING = 2'b01,
      SBA_ASLEEP   = 2'b10,
      SBA_LEAVING  = 2'b11
   } sba_sleep_type;
endpackage : sba_pkg

// ### rtl/sba_sleep_ctrl.sv
// sleep entry and exit sequencer, two clock periods each way
`timescale 1ns/1ps
`default_nettype none
module sba_sleep_ctrl (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic clk_en,
   input  wire logic sleep_req,
   output logic      halted
);
   localparam logic [1:0] LAST = 2'(sba_pkg::SLEEP_TRANSITION_CYCLES - 1);

   sba_pkg::sba_sleep_type state;
   sba_pkg::sba_sleep_type next_state;
   logic [1:0]             count;
   logic [1:0]             next_count;

   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         sba_pkg::SBA_AWAKE: begin
            if (sleep_req) begin
               next_state = sba_pkg::SBA_ENTERING;
               next_count = 2'h0;
            end
         end
         sba_pkg::SBA_ENTERING: begin
            if (count == LAST) begin
               next_state = sba_pkg::SBA_ASLEEP;
            end else begin
               next_count = count + 2'h1;
            end
         end
         sba_pkg::SBA_ASLEEP: begin
            if (!sleep_req) begin
               next_state = sba_pkg::SBA_LEAVING;
               next_count = 2'h0;
            end
         end
         sba_pkg::SBA_LEAVING: begin
            if (count == LAST) begin
               next_state = sba_pkg::SBA_AWAKE;
            end else begin
               next_count = count + 2'h1;
            end
         end
         default: begin
            next_state = sba_pkg::SBA_AWAKE;
            next_count = 2'h0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= sba_pkg::SBA_AWAKE;
         count <= 2'h0;
      end else if (clk_en) begin
         state <= next_state;
         count <= next_count;
      end
   end

   assign halted = (state != sba_pkg::SBA_AWAKE);

   property p_entry_time;
      @(posedge clock) disable iff (!rst_n)
      (state == sba_pkg::SBA_AWAKE && sleep_req && clk_en) ##1 clk_en ##1 clk_en
         |=> (state == sba_pkg::SBA_ASLEEP);
   endproperty
   a_entry_time: assert property (p_entry_time) else $error("sleep entry not 2 cycles");
endmodule : sba_sleep_ctrl
`default_nettype wire

// ### rtl/sba_sram_access.sv
// synchronous flow-through burst sram access logic with common data pins
`timescale 1ns/1ps
`default_nettype none
module sba_sram_access #(
   parameter int ADDR_WIDTH = sba_pkg::ADDR_WIDTH,
   parameter int LANES      = sba_pkg::LANES
) (
   input  wire logic                              clock,
   input  wire logic                              rst_n,
   input  wire logic                              clk_en,
   input  wire logic [ADDR_WIDTH-1:0]             address,
   input  wire logic                              chip_enable1_n,
   input  wire logic                              chip_enable2,
   input  wire logic                              chip_enable3_n,
   input  wire logic                              proc_addr_strobe_n,
   input  wire logic                              ctrl_addr_strobe_n,
   input  wire logic                              burst_step_n,
   input  wire logic                              global_write_n,
   input  wire logic                              byte_write_gate_n,
   input  wire logic [LANES-1:0]                  byte_lane_select_n,
   input  wire logic                              output_enable_n,
   input  wire logic                              sleep_request,
   input  wire logic                              burst_order,
   input  wire logic [LANES*sba_pkg::LANE_BITS-1:0] data_in,
   input  wire logic [LANES-1:0]                  lane_parity_bit_in,
   output logic [LANES*sba_pkg::LANE_BITS-1:0]    data_out,
   output logic [LANES-1:0]                       lane_parity_bit_out,
   output logic                                   data_oe,
   output logic                                   parity_oe,
   output logic                                   sleep_active
);
   localparam int LB    = sba_pkg::LANE_BITS;
   localparam int SLICE = LB + 1;
   localparam int DEPTH = 1 << ADDR_WIDTH;

   logic rst_meta;
   logic rst_sync;
   logic oe_meta_n;
   logic oe_sync_n;
   logic slp_meta;
   logic slp_sync;
   logic order_taken;
   logic order_strap;
   logic halted;

   sba_pkg::sba_sel_type         sel;
   sba_pkg::sba_sel_type         next_sel;
   logic                         pending;
   logic                         next_pending;
   logic [ADDR_WIDTH-1:2]        addr_upper;
   logic [ADDR_WIDTH-1:2]        next_addr_upper;
   logic [LANES*LB-1:0]          next_data_out;
   logic [LANES-1:0]             next_parity_out;
   logic                         next_data_oe;
   logic                         next_reading;
   logic                         next_first;
   logic                         write_ind;
   logic [LANES-1:0]             lane_we;
   logic                         chips_on;
   logic                         proc_start;
   logic                         acc_valid;
   logic                         acc_write;
   logic [ADDR_WIDTH-1:0]        acc_addr;
   logic [LANES*SLICE-1:0]       rd_word;
   logic [LANES*SLICE-1:0]       mem [DEPTH];

   sba_burst_if bus ();

   sba_burst_counter u_counter (
      .clock  (clock),
      .rst_n  (rst_sync),
      .clk_en (clk_en),
      .bus    (bus.counter)
   );

   sba_sleep_ctrl u_sleep (
      .clock     (clock),
      .rst_n     (rst_sync),
      .clk_en    (clk_en),
      .sleep_req (slp_sync),
      .halted    (halted)
   );

   // reset release, then the asynchronous pins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'h0;
         rst_sync <= 1'h0;
      end else if (clk_en) begin
         rst_meta <= 1'h1;
         rst_sync <= rst_meta;
      end
   end

   always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
         oe_meta_n <= sba_pkg::RESET_OE_SYNC_N;
         oe_sync_n <= sba_pkg::RESET_OE_SYNC_N;
         slp_meta  <= sba_pkg::RESET_SLEEP_SYNC;
         slp_sync  <= sba_pkg::RESET_SLEEP_SYNC;
      end else if (clk_en) begin
         oe_meta_n <= output_enable_n;
         oe_sync_n <= oe_meta_n;
         slp_meta  <= sleep_request;
         slp_sync  <= slp_meta;
      end
   end

   // strap caught once after reset release
   always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
         order_taken <= 1'h0;
         order_strap <= sba_pkg::RESET_ORDER;
      end else if (clk_en && !order_taken) begin
         order_taken <= 1'h1;
         order_strap <= burst_order;
      end
   end

   assign rd_word = mem[acc_addr];

   always_comb begin
      write_ind = !global_write_n
                  || (!byte_write_gate_n && !(&byte_lane_select_n));
      if (!global_write_n) begin
         lane_we = '1;
      end else if (!byte_write_gate_n) begin
         lane_we = ~byte_lane_select_n;
      end else begin
         lane_we = '0;
      end
      chips_on   = chip_enable2 && !chip_enable3_n;
      proc_start = !proc_addr_strobe_n && !chip_enable1_n;
      next_sel        = sel;
      next_pending    = 1'h0;
      next_addr_upper = addr_upper;
      acc_valid       = 1'h0;
      acc_write       = 1'h0;
      acc_addr        = {addr_upper, bus.low_addr};
      bus.load        = 1'h0;
      bus.load_value  = address[1:0];
      bus.step        = 1'h0;
      bus.order       = order_strap;
      if (halted) begin
         next_sel = sba_pkg::SBA_DESEL;
      end else if (proc_start) begin
         if (chips_on) begin
            next_sel        = sba_pkg::SBA_SEL;
            next_pending    = 1'h1;
            acc_valid       = 1'h1;
            acc_addr        = address;
            bus.load        = 1'h1;
            next_addr_upper = address[ADDR_WIDTH-1:2];
         end else begin
            next_sel = sba_pkg::SBA_DESEL;
         end
      end else if (!ctrl_addr_strobe_n) begin
         if (!chip_enable1_n && chips_on) begin
            next_sel        = sba_pkg::SBA_SEL;
            acc_valid       = 1'h1;
            acc_write       = write_ind;
            acc_addr        = address;
            bus.load        = 1'h1;
            next_addr_upper = address[ADDR_WIDTH-1:2];
         end else begin
            next_sel = sba_pkg::SBA_DESEL;
         end
      end else if (sel == sba_pkg::SBA_SEL) begin
         acc_valid = 1'h1;
         acc_write = write_ind;
         if (!(pending && write_ind)) begin
            bus.step = !burst_step_n;
            acc_addr = {addr_upper, bus.step ? bus.low_next : bus.low_addr};
         end
      end
      next_reading = acc_valid && !acc_write;
      next_first   = next_reading && (sel == sba_pkg::SBA_DESEL);
      next_data_oe = next_reading && !oe_sync_n && !next_first;
      next_data_out   = data_out;
      next_parity_out = lane_parity_bit_out;
      if (next_reading) begin
         for (int k = 0; k < LANES; k++) begin
            next_data_out[k*LB +: LB] = rd_word[k*SLICE +: LB];
            next_parity_out[k]        = rd_word[k*SLICE + LB];
         end
      end
   end

   always_ff @(posedge clock or negedge rst_sync) begin
      if (!rst_sync) begin
         sel                 <= sba_pkg::SBA_DESEL;
         pending             <= 1'h0;
         addr_upper          <= '0;
         data_out            <= '0;
         lane_parity_bit_out <= '0;
         data_oe             <= 1'h0;
         parity_oe           <= 1'h0;
         sleep_active        <= 1'h0;
      end else if (clk_en) begin
         sel                 <= next_sel;
         pending             <= next_pending;
         addr_upper          <= next_addr_upper;
         data_out            <= next_data_out;
         lane_parity_bit_out <= next_parity_out;
         data_oe             <= next_data_oe;
         parity_oe           <= next_data_oe;
         sleep_active        <= halted;
      end
   end

   // storage keeps its contents through reset and sleep
   always_ff @(posedge clock) begin
      if (clk_en && rst_sync && acc_valid && acc_write) begin
         for (int k = 0; k < LANES; k++) begin
            if (lane_we[k]) begin
               mem[acc_addr][k*SLICE +: SLICE] <= {lane_parity_bit_in[k],
                                                   data_in[k*LB +: LB]};
            end
         end
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_sync);

   property p_proc_reads;
      (clk_en && !halted && proc_start && chips_on) |-> (acc_valid && !acc_write);
   endproperty
   a_proc_reads: assert property (p_proc_reads) else $error("processor start wrote");

   property p_second_write;
      (clk_en && !halted && proc_start && chips_on)
         ##1 (clk_en && !halted && proc_addr_strobe_n && ctrl_addr_strobe_n && write_ind)
         |-> (acc_write && acc_addr == $past(address));
   endproperty
   a_second_write: assert property (p_second_write) else $error("late write misplaced");

   property p_ctrl_write;
      (clk_en && !halted && proc_addr_strobe_n && !ctrl_addr_strobe_n
         && !chip_enable1_n && chips_on && write_ind) |-> (acc_write && acc_addr == address);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("controller write missed");

   property p_proc_priority;
      (clk_en && !halted && !proc_addr_strobe_n && !ctrl_addr_strobe_n
         && !chip_enable1_n && chips_on && write_ind) |-> !acc_write;
   endproperty
   a_proc_priority: assert property (p_proc_priority) else $error("controller strobe won");

   property p_write_floats;
      (clk_en && acc_valid && acc_write) |=> (!data_oe && !parity_oe);
   endproperty
   a_write_floats: assert property (p_write_floats) else $error("drove during write");

   property p_deselect;
      (clk_en && !halted && (proc_start || !ctrl_addr_strobe_n)
         && (!chips_on || chip_enable1_n)) |=> (sel == sba_pkg::SBA_DESEL && !data_oe);
   endproperty
   a_deselect: assert property (p_deselect) else $error("deselect ignored");

   property p_write_decode;
      (clk_en && acc_write) |-> (!global_write_n || (lane_we != '0 && !byte_write_gate_n));
   endproperty
   a_write_decode: assert property (p_write_decode) else $error("write without cause");

   property p_oe_gate;
      $rose(data_oe) |-> (!$past(oe_sync_n) && $past(next_reading));
   endproperty
   a_oe_gate: assert property (p_oe_gate) else $error("drove without enable");

   property p_sleep_float;
      sleep_active |-> (!data_oe && !parity_oe);
   endproperty
   a_sleep_float: assert property (p_sleep_float) else $error("drove while asleep");

   property p_first_mask;
      (clk_en && sel == sba_pkg::SBA_DESEL && next_reading) |=> !data_oe;
   endproperty
   a_first_mask: assert property (p_first_mask) else $error("first read drove");

   property p_upper_hold;
      (clk_en && !bus.load) |=> $stable(addr_upper);
   endproperty
   a_upper_hold: assert property (p_upper_hold) else $error("upper address moved");

   c_proc_then_write: cover property (
      (clk_en && proc_start && chips_on && !halted) ##1 (clk_en && acc_write));
   c_ctrl_write: cover property (clk_en && !ctrl_addr_strobe_n && acc_write);
   c_burst_read: cover property ((data_oe && bus.step) [*3]);
   c_sleep: cover property ($rose(sleep_active));
endmodule : sba_sram_access
`default_nettype wire

// ### test/sba_master.sv
// bus master model for the synchronous sram bus
`timescale 1ns/1ps
`default_nettype none
module sba_master (
   input  wire logic   clock,
   output logic [5:0]  address,
   output logic        chip_enable2,
   output logic        proc_addr_strobe_n,
   output logic        ctrl_addr_strobe_n,
   output logic        burst_step_n,
   output logic        global_write_n,
   output logic        byte_write_gate_n,
   output logic [3:0]  byte_lane_select_n,
   output logic        output_enable_n,
   output logic        sleep_request,
   output logic [31:0] data_in,
   output logic [3:0]  lane_parity_bit_in
);
   initial begin
      {chip_enable2, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, global_write_n,
       byte_write_gate_n, byte_lane_select_n} = 10'h0ff;
      address = 6'h00;
      output_enable_n = 1'b0;
      sleep_request = 1'b0;
      data_in = 32'h0000_0000;
      lane_parity_bit_in = 4'h0;
   end
   // one bus cycle; data lines toggle when not writing
   task automatic op(input logic [9:0] c, input logic [5:0] a, input logic [31:0] d);
      logic wr;
      wr = !c[5] || (!c[4] && c[3:0] != 4'hf);
      @(posedge clock);
      {chip_enable2, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, global_write_n,
       byte_write_gate_n, byte_lane_select_n} <= c;
      address <= a;
      output_enable_n <= wr && c[8];
      data_in <= wr ? d : ~data_in;
      lane_parity_bit_in <= wr ? d[7:4] : ~lane_parity_bit_in;
   endtask : op
   // callers deselect before raising and idle after dropping
   task automatic nap(input logic v);
      @(posedge clock);
      sleep_request <= v;
   endtask : nap
endmodule : sba_master
`default_nettype wire

// ### test/sba_sram_access_bench.sv
// self-checking bench of the sram access block
`timescale 1ns/1ps
`default_nettype none
module sba_sram_access_bench;
   localparam logic [9:0] DESEL = 10'h0ff, CWR = 10'h35f, CONTW = 10'h39f, RSTART = 10'h25f;
   localparam logic [9:0] SUSP = 10'h3ff, STEP = 10'h3bf, PSTART = 10'h2ff, BYTEW = 10'h3ea;
   localparam logic [9:0] BREAD = 10'h3ef, PSTEP = 10'h2bf, IDLE = 10'h1ff;
   logic        clock, rst_n, burst_order, chip_enable2, proc_addr_strobe_n;
   logic        ctrl_addr_strobe_n, burst_step_n, global_write_n, byte_write_gate_n;
   logic        output_enable_n, sleep_request, data_oe, parity_oe, sleep_active;
   logic [5:0]  address;
   logic        clk_en = 1'b1, chip_enable1_n = 1'b0, chip_enable3_n = 1'b0;
   logic [3:0]  byte_lane_select_n, lane_parity_bit_in, lane_parity_bit_out;
   logic [31:0] data_in, data_out;
   logic [31:0] em [64];
   logic [3:0]  ep [64];
   int          errors = 0, total_checks = 0;

   sba_sram_access #(.ADDR_WIDTH(6)) sba_sram_access_i (
      .clock, .rst_n, .clk_en, .address, .chip_enable1_n, .chip_enable2,
      .chip_enable3_n, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_step_n,
      .global_write_n, .byte_write_gate_n, .byte_lane_select_n, .output_enable_n,
      .sleep_request, .burst_order, .data_in, .lane_parity_bit_in, .data_out,
      .lane_parity_bit_out, .data_oe, .parity_oe, .sleep_active);
   sba_master sba_master_i (
      .clock, .address, .chip_enable2, .proc_addr_strobe_n, .ctrl_addr_strobe_n,
      .burst_step_n, .global_write_n, .byte_write_gate_n, .byte_lane_select_n,
      .output_enable_n, .sleep_request, .data_in, .lane_parity_bit_in);

   always #50 clock = ~clock;

   task automatic chk(input logic [37:0] s, input logic [37:0] e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %0t got %h want %h", $time, s, e);
      end
   endtask : chk

   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done

   task automatic wr_burst;
      logic [5:0]  b;
      logic [31:0] d;
      for (int i = 0; i < 5; i++) begin
         b = {4'h1, 2'h1 ^ 2'(i)};
         d = 32'h1357_9bdf * (i + 1);
         sba_master_i.op(i == 0 ? CWR : i < 4 ? CONTW : DESEL, 6'h05, d);
         if (i < 4) begin
            em[b] = d;
            ep[b] = d[7:4];
         end
         @(negedge clock);
         if (i > 0) chk({36'h0, data_oe, parity_oe}, 38'h0);
      end
   endtask : wr_burst

   task automatic byte_wr;
      sba_master_i.op(PSTART, 6'h06, 32'h0);
      sba_master_i.op(BYTEW, 6'h06, 32'ha5a5_a5a5);
      em[6][7:0] = 8'ha5;
      em[6][23:16] = 8'ha5;
      ep[6][0] = 1'b0;
      ep[6][2] = 1'b0;
      sba_master_i.op(BREAD, 6'h06, 32'h0);
      @(negedge clock);
      chk({36'h0, data_oe, parity_oe}, 38'h0);
      repeat (2) sba_master_i.op(DESEL, 6'h00, 32'h0);
   endtask : byte_wr

   task automatic rd(input logic [5:0] a, input logic lin);
      logic [5:0] b;
      sba_master_i.op(RSTART, a, 32'hdead_beef);
      sba_master_i.op(SUSP, a, 32'h0);
      @(negedge clock);
      chk({36'h0, data_oe, parity_oe}, 38'h0);
      for (int i = 0; i < 4; i++) begin
         sba_master_i.op(i < 3 ? STEP : DESEL, a, 32'h0);
         @(negedge clock);
         b = lin ? {a[5:2], a[1:0] + 2'(i)} : {a[5:2], a[1:0] ^ 2'(i)};
         chk({data_oe, parity_oe, lane_parity_bit_out, data_out}, {2'b11, ep[b], em[b]});
      end
      sba_master_i.op(DESEL, a, 32'h0);
      @(negedge clock);
      chk({36'h0, data_oe, parity_oe}, 38'h0);
   endtask : rd

   task automatic wait_sleep(input logic v);
      for (int n = 0; n < 20 && sleep_active !== v; n++) @(negedge clock);
      if (sleep_active !== v) begin
         errors++;
         $display("[FAIL] %0t sleep state wait ran out", $time);
         test_done;
      end
   endtask : wait_sleep

   // chip enables and clock enable: deselect, ignored strobe, frozen state
   task automatic pins;
      sba_master_i.op(PSTART, 6'h05, 32'h0);
      chip_enable3_n <= 1'b1;
      sba_master_i.op(SUSP, 6'h05, 32'h0);
      chip_enable3_n <= 1'b0;
      sba_master_i.op(PSTART, 6'h05, 32'h0);
      @(negedge clock);
      chk({36'h0, data_oe, parity_oe}, 38'h0);
      sba_master_i.op(PSTEP, 6'h00, 32'h0);
      chip_enable1_n <= 1'b1;
      sba_master_i.op(STEP, 6'h05, 32'h0);
      chip_enable1_n <= 1'b0;
      clk_en <= 1'b0;
      @(negedge clock);
      chk({data_oe, parity_oe, lane_parity_bit_out, data_out}, {2'b11, ep[4], em[4]});
      sba_master_i.op(STEP, 6'h05, 32'h0);
      clk_en <= 1'b1;
      @(negedge clock);
      chk({data_oe, parity_oe, lane_parity_bit_out, data_out}, {2'b11, ep[4], em[4]});
      sba_master_i.op(DESEL, 6'h00, 32'h0);
      @(negedge clock);
      chk({data_oe, parity_oe, lane_parity_bit_out, data_out}, {2'b11, ep[7], em[7]});
      sba_master_i.op(DESEL, 6'h00, 32'h0);
   endtask : pins

   task automatic nap;
      sba_master_i.op(IDLE, 6'h00, 32'h0);
      chip_enable1_n <= 1'b1;
      chip_enable3_n <= 1'b1;
      sba_master_i.nap(1'b1);
      wait_sleep(1'b1);
      chk({36'h0, data_oe, parity_oe}, 38'h0);
      sba_master_i.nap(1'b0);
      wait_sleep(1'b0);
      repeat (3) sba_master_i.op(IDLE, 6'h00, 32'h0);
      chip_enable1_n <= 1'b0;
      chip_enable3_n <= 1'b0;
   endtask : nap

   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      burst_order = 1'b1;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) sba_master_i.op(DESEL, 6'h00, 32'h0);
      wr_burst;
      byte_wr;
      rd(6'h05, 1'b0);
      pins;
      nap;
      rd(6'h04, 1'b0);
      @(posedge clock);
      rst_n <= 1'b0;
      burst_order <= 1'b0;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) sba_master_i.op(DESEL, 6'h00, 32'h0);
      rd(6'h06, 1'b1);
      test_done;
   end
endmodule : sba_sram_access_bench
`default_nettype wire
